// ### slh_status.sv
/*
 * status lamps and per-node health codes behind an apb slave.
 * assumes pclk at 10 MHz; bus-off and cpu pins are asynchronous.
 */
// Notes on behaviour
// - run lamp dark in init or bootstrap state.
// - run lamp flashes at 2 Hz in preop.
// - run lamp flashes 1 Hz in safeop; outputs held safe.
// - run lamp steadily lit in op.
// - error lamp dark when all configured nodes healthy and task runs.
// - error lamp flashes 1 Hz when any configured node code nonzero.
// - error lamp flashes 10 Hz during configuration upload.
// - error lamp steady on bus-off, held until restart.
// - cpu lamp flashes 10 Hz at start-up, steady on processor error.
// - each node has a readable 8-bit health code, updated at run time.
// - health codes run 0 to 11 with defined meanings.
// - code 11 reported when own controller is bus-off.
// - code 8 reported while a found node is still starting.
`timescale 1ns/1ps
`default_nettype none
`include "slh_defines.svh"
module slh_status
    import slh_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // asynchronous status pins
    input  wire logic        can_bus_off,
    input  wire logic        cpu_starting,
    input  wire logic        cpu_error,
    // lamps and interrupt
    output logic             lamp_run,
    output logic             lamp_err,
    output logic             lamp_cpu,
    output logic             outputs_safe,
    output logic             irq
);
    slh_tb_if tb ();

    slh_flash u_flash (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .tb      (tb.gen)
    );

    // two-flop synchronisers for the pin inputs
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
        end else if (ce) begin
            s1_reg <= {cpu_error, cpu_starting, can_bus_off};
            s2_reg <= s1_reg;
        end
    end
    // registers
    logic [31:0]         ctrl_reg;
    logic [`SLH_NODES-1:0] cfg_reg;
    logic bo_pin;
    logic cpu_st;
    logic cpu_er;
    assign bo_pin = s2_reg[0];
    assign cpu_st = s2_reg[1] | ctrl_reg[`SLH_C_CPU_START];
    assign cpu_er = s2_reg[2] | ctrl_reg[`SLH_C_CPU_ERR];
    logic [`SLH_NEV-1:0] ist_reg;
    logic [`SLH_NEV-1:0] imask_reg;
    slh_code_t           node_reg [`SLH_NODES];
    slh_bo_t             bo_reg;
    logic [2:0]          fsm;
    assign fsm = ctrl_reg[`SLH_C_FSM_HI:`SLH_C_FSM_LO];

    // bus-off latches until restart (reset) or software restart bit while the pin is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_reg <= SLH_BO_IDLE;
        end else if (ce) begin
            unique case (bo_reg)
                SLH_BO_IDLE: begin
                    if (bo_pin) bo_reg <= SLH_BO_SET;
                end
                SLH_BO_SET: begin
                    bo_reg <= SLH_BO_HELD;
                end
                SLH_BO_HELD: begin
                    if (ctrl_reg[`SLH_C_BUSOFF_CLR] && !bo_pin) begin
                        bo_reg <= SLH_BO_IDLE;
                    end
                end
                default: bo_reg <= SLH_BO_IDLE;
            endcase
        end
    end
    logic bo_on;
    assign bo_on = (bo_reg != SLH_BO_IDLE);

    // node fault aggregate over configured nodes
    logic [`SLH_NODES-1:0] nf;
    genvar gi;
    generate
        for (gi = 0; gi < `SLH_NODES; gi++) begin : g_nf
            assign nf[gi] = cfg_reg[gi] &&
                            (node_reg[gi] != `SLH_HC_OK);
        end
    endgenerate
    logic any_fault;
    assign any_fault = |nf;

    // apb: zero wait state, pready high from the first ce edge after reset
    logic wr_en;
    logic rd_en;
    logic node_hit;
    logic [2:0] node_idx;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !penable && !pwrite;
    assign node_hit = (paddr >= `SLH_A_NODE_BASE) &&
                      (paddr <= `SLH_A_NODE_LAST) && (paddr[1:0] == 2'h0);
    assign node_idx = paddr[4:2];
    logic mapped;
    assign mapped = node_hit || paddr == `SLH_A_CTRL ||
                    paddr == `SLH_A_STAT || paddr == `SLH_A_IRQ_STAT ||
                    paddr == `SLH_A_IRQ_MASK || paddr == `SLH_A_NODE_CFG;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= 32'h0000_0008;
            cfg_reg   <= '0;
            imask_reg <= '0;
        end else if (ce && wr_en) begin
            if (paddr == `SLH_A_CTRL)     ctrl_reg  <= pwdata;
            if (paddr == `SLH_A_NODE_CFG) cfg_reg   <= pwdata[`SLH_NODES-1:0];
            if (paddr == `SLH_A_IRQ_MASK) imask_reg <= pwdata[`SLH_NEV-1:0];
        end
    end

    // node codes: written by supervisor, clamped to 0..11, bus-off forced
    generate
        for (gi = 0; gi < `SLH_NODES; gi++) begin : g_node
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    node_reg[gi] <= `SLH_HC_STARTUP;
                end else if (ce) begin
                    if (bo_on) begin
                        node_reg[gi] <= `SLH_HC_BUSOFF;
                    end else if (wr_en && node_hit &&
                                 node_idx == 3'(gi)) begin
                        node_reg[gi] <= (pwdata[7:0] > `SLH_HC_MAX) ?
                            `SLH_HC_MAX : pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // sticky events, set wins over write-one-to-clear
    logic [`SLH_NEV-1:0] ev;
    logic                bo_d_reg;
    logic                fault_d_reg;
    logic [2:0]          fsm_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_d_reg    <= 1'b0;
            fault_d_reg <= 1'b0;
            fsm_d_reg   <= `SLH_FSM_INIT;
        end else if (ce) begin
            bo_d_reg    <= bo_on;
            fault_d_reg <= any_fault;
            fsm_d_reg   <= fsm;
        end
    end
    assign ev[`SLH_E_BUSOFF] = bo_on && !bo_d_reg;
    assign ev[`SLH_E_FAULT]  = any_fault && !fault_d_reg;
    assign ev[`SLH_E_FSM]    = fsm != fsm_d_reg;

    logic [`SLH_NEV-1:0] clr;
    assign clr = (wr_en && paddr == `SLH_A_IRQ_STAT) ?
                 pwdata[`SLH_NEV-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_reg <= '0;
        end else if (ce) begin
            ist_reg <= (ist_reg & ~clr) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(ist_reg & imask_reg);
        end
    end

    // read data captured in setup so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else if (ce) begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && !mapped;
            if (rd_en) begin
                prdata <= 32'h0000_0000;
                if (node_hit) begin
                    prdata <= {24'h000000, node_reg[node_idx]};
                end else if (paddr == `SLH_A_CTRL) begin
                    prdata <= ctrl_reg;
                end else if (paddr == `SLH_A_STAT) begin
                    prdata <= {24'h000000, any_fault, bo_on,
                               lamp_cpu, lamp_err, lamp_run, fsm};
                end else if (paddr == `SLH_A_IRQ_STAT) begin
                    prdata <= {29'h0, ist_reg};
                end else if (paddr == `SLH_A_IRQ_MASK) begin
                    prdata <= {29'h0, imask_reg};
                end else if (paddr == `SLH_A_NODE_CFG) begin
                    prdata <= {24'h000000, cfg_reg};
                end
            end
        end
    end

    // run lamp from fieldbus state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_run     <= 1'b0;
            outputs_safe <= 1'b1;
        end else if (ce) begin
            outputs_safe <= (fsm != `SLH_FSM_OP);
            if (fsm == `SLH_FSM_OP) begin
                lamp_run <= 1'b1;
            end else if (fsm == `SLH_FSM_SAFEOP) begin
                lamp_run <= tb.f1;
            end else if (fsm == `SLH_FSM_PREOP) begin
                lamp_run <= tb.f2;
            end else begin
                lamp_run <= 1'b0;
            end
        end
    end

    // error lamp: bus-off first, then upload, then node fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_err <= 1'b0;
        end else if (ce) begin
            if (bo_on) begin
                lamp_err <= 1'b1;
            end else if (ctrl_reg[`SLH_C_UPLOAD]) begin
                lamp_err <= tb.f10;
            end else if (any_fault || !ctrl_reg[`SLH_C_TASK_RUN]) begin
                lamp_err <= tb.f1;
            end else begin
                lamp_err <= 1'b0;
            end
        end
    end

    // cpu lamp: error steady, start-up flashing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_cpu <= 1'b0;
        end else if (ce) begin
            if (cpu_er) begin
                lamp_cpu <= 1'b1;
            end else if (cpu_st) begin
                lamp_cpu <= tb.f10;
            end else begin
                lamp_cpu <= 1'b0;
            end
        end
    end
endmodule : slh_status
`default_nettype wire

// ### slh_defines.svh
/*
 * constants for the status lamp and node health block.
 * assumes pclk at 10 MHz.
 */
`ifndef SLH_DEFINES_SVH
`define SLH_DEFINES_SVH
`define SLH_CLK_HZ        10000000
`define SLH_TICK_HZ       20
`define SLH_TICK_DIV      (`SLH_CLK_HZ / `SLH_TICK_HZ)
`define SLH_NODES         8
`define SLH_HC_OK         8'h00
`define SLH_HC_DEACT      8'h01
`define SLH_HC_ABSENT     8'h02
`define SLH_HC_STARTUP    8'h08
`define SLH_HC_BUSOFF     8'h0b
`define SLH_HC_MAX        8'h0b
`define SLH_A_CTRL        12'h000
`define SLH_A_STAT        12'h004
`define SLH_A_IRQ_STAT    12'h008
`define SLH_A_IRQ_MASK    12'h00c
`define SLH_A_NODE_CFG    12'h010
`define SLH_A_NODE_BASE   12'h020
`define SLH_A_NODE_LAST   12'h03c
`define SLH_FSM_INIT      3'h0
`define SLH_FSM_PREOP     3'h1
`define SLH_FSM_BOOT      3'h2
`define SLH_FSM_SAFEOP    3'h3
`define SLH_FSM_OP        3'h4
`define SLH_C_UPLOAD      0
`define SLH_C_CPU_START   1
`define SLH_C_CPU_ERR     2
`define SLH_C_TASK_RUN    3
`define SLH_C_FSM_LO      4
`define SLH_C_FSM_HI      6
`define SLH_C_BUSOFF_CLR  7
`define SLH_E_BUSOFF      0
`define SLH_E_FAULT       1
`define SLH_E_FSM         2
`define SLH_NEV           3
`endif

// ### slh_pkg.sv
/*
 * types for the status lamp block.
 * assumes slh_defines.svh is available.
 */
package slh_pkg;
    typedef enum logic [2:0] {
        SLH_BO_IDLE = 3'b001,
        SLH_BO_SET  = 3'b010,
        SLH_BO_HELD = 3'b100
    } slh_bo_t;
    typedef logic [7:0] slh_code_t;
endpackage : slh_pkg

// ### slh_tb_if.sv
/*
 * time base carrier between the top and the flash generator.
 * assumes one clock domain, pclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface slh_tb_if;
    logic tick;
    logic f1;
    logic f2;
    logic f10;
    modport gen (output tick, output f1, output f2, output f10);
    modport use_ (input tick, input f1, input f2, input f10);
endinterface : slh_tb_if
`default_nettype wire

// ### slh_flash.sv
/*
 * shared time base producing 1, 2 and 10 Hz square waves.
 * assumes pclk at the rate in slh_defines.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slh_defines.svh"
module slh_flash
    import slh_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    // time base
    slh_tb_if.gen     tb
);
    logic [23:0] div_reg;
    logic [3:0]  ph_reg;
    logic        f1_reg;
    logic        f2_reg;
    logic        f10_reg;
    logic        tick_reg;

    // one divider feeds every rate, so patterns stay in step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 24'h000000;
            tick_reg <= 1'b0;
        end else if (ce) begin
            tick_reg <= 1'b0;
            if (div_reg == 24'(`SLH_TICK_DIV - 1)) begin
                div_reg  <= 24'h000000;
                tick_reg <= 1'b1;
            end else begin
                div_reg <= div_reg + 24'h000001;
            end
        end
    end

    // 20 Hz ticks: toggle each tick gives 10 Hz, 50 % duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_reg  <= 4'h0;
            f1_reg  <= 1'b0;
            f2_reg  <= 1'b0;
            f10_reg <= 1'b0;
        end else if (ce && tick_reg) begin
            f10_reg <= ~f10_reg;
            ph_reg  <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
            if (ph_reg == 4'h4 || ph_reg == 4'h9) begin
                f2_reg <= ~f2_reg;
            end
            if (ph_reg == 4'h9) begin
                f1_reg <= ~f1_reg;
            end
        end
    end

    assign tb.tick = tick_reg;
    assign tb.f1   = f1_reg;
    assign tb.f2   = f2_reg;
    assign tb.f10  = f10_reg;
endmodule : slh_flash
`default_nettype wire

// ### slh_status_checker.sv
/*
 * port checker for the status lamp block, bound to slh_status.
 * assumes ce stays high around pin events and zero-wait apb.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slh_defines.svh"
module slh_status_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins, lamps and interrupt
    input wire logic        can_bus_off,
    input wire logic        cpu_starting,
    input wire logic        cpu_error,
    input wire logic        lamp_run,
    input wire logic        lamp_err,
    input wire logic        lamp_cpu,
    input wire logic        outputs_safe,
    input wire logic        irq
);
    logic [7:0] ctrl_q;
    logic [2:0] fsm;
    logic       bo_q;
    logic       wr_ctrl;
    logic       rd_node;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign fsm     = ctrl_q[6:4];
    assign wr_ctrl = psel && penable && pwrite && paddr == `SLH_A_CTRL;
    assign rd_node = psel && penable && !pwrite &&
                     paddr >= `SLH_A_NODE_BASE && paddr <= `SLH_A_NODE_LAST;
    // shadow of the control word, landing where the write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h08;
        end else if (wr_ctrl && ce) begin
            ctrl_q <= pwdata[7:0];
        end
    end
    // raw pin: hold check starts before the synchroniser catches up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_q <= 1'b0;
        end else if (can_bus_off) begin
            bo_q <= 1'b1;
        end else if (wr_ctrl && pwdata[`SLH_C_BUSOFF_CLR]) begin
            bo_q <= 1'b0;
        end
    end
    chk_run_dark: assert property (
        ce && (fsm == `SLH_FSM_INIT || fsm == `SLH_FSM_BOOT) |=> !lamp_run)
        else $error("run lamp lit in init or bootstrap");
    chk_run_op: assert property (
        ce && fsm == `SLH_FSM_OP |=> lamp_run)
        else $error("run lamp dark in op");
    chk_safe_state: assert property (
        ce |=> outputs_safe == ($past(fsm) != `SLH_FSM_OP))
        else $error("safe output flag wrong for state");
    chk_busoff_rise: assert property (
        ce && $rose(can_bus_off) |-> ##[1:4] lamp_err)
        else $error("bus-off lamp late");
    chk_busoff_hold: assert property (
        bo_q && lamp_err && !(wr_ctrl && pwdata[7]) |=> lamp_err)
        else $error("bus-off lamp dropped before restart");
    chk_busoff_code: assert property (
        rd_node && bo_q && $past(bo_q, 5) |-> prdata[7:0] == `SLH_HC_BUSOFF)
        else $error("node code not bus-off code");
    chk_code_range: assert property (
        rd_node |-> prdata[7:0] <= `SLH_HC_MAX)
        else $error("node code out of range");
    chk_cpu_pin: assert property (
        (ce && cpu_error) [*6] |-> lamp_cpu)
        else $error("cpu lamp dark on pin error");
    chk_cpu_ctrl: assert property (
        ce && ctrl_q[`SLH_C_CPU_ERR] |=> lamp_cpu)
        else $error("cpu lamp dark on control error");
    cov_busoff: cover property (bo_q && lamp_err);
    cov_op: cover property (fsm == `SLH_FSM_OP && lamp_run);
    cov_cpu: cover property (lamp_cpu && cpu_error);
endmodule : slh_status_checker
bind slh_status slh_status_checker u_slh_status_checker (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_bus_off(can_bus_off), .cpu_starting(cpu_starting),
    .cpu_error(cpu_error), .lamp_run(lamp_run), .lamp_err(lamp_err),
    .lamp_cpu(lamp_cpu), .outputs_safe(outputs_safe), .irq(irq));
`default_nettype wire

// ### slh_lamp_obs.sv
/*
 * lamp watcher: counts every change of the run and error lamps.
 * assumes lamps are sampled on pclk; clr zeroes the count.
 */
`timescale 1ns/1ps
`default_nettype none
module slh_lamp_obs (
    // clock, reset and clear
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clr,
    // lamps
    input  wire logic        lamp_run,
    input  wire logic        lamp_err,
    // changes seen since clear
    output logic      [15:0] changes
);
    logic run_q;
    logic err_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            changes <= '0;
            run_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            run_q <= lamp_run;
            err_q <= lamp_err;
            // a steady lamp adds nothing; a glitch shows as two
            changes <= clr ? 16'h0 : changes + 16'(run_q != lamp_run)
                       + 16'(err_q != lamp_err);
        end
    end
endmodule : slh_lamp_obs
`default_nettype wire

// ### tb_top.sv
/*
 * self-checking bench for the status lamp block.
 * assumes zero-wait apb; flash periods are too long to watch here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slh_defines.svh"
module tb_top import slh_pkg::*;;
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, err, obs_clr;
    logic        can_bus_off, cpu_starting, cpu_error, irq;
    logic        lamp_run, lamp_err, lamp_cpu, outputs_safe;
    logic [15:0] changes;
    int          checked, miscompares, cycles;
    slh_status u_slh_status (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .can_bus_off(can_bus_off),
        .cpu_starting(cpu_starting), .cpu_error(cpu_error),
        .lamp_run(lamp_run), .lamp_err(lamp_err), .lamp_cpu(lamp_cpu),
        .outputs_safe(outputs_safe), .irq(irq));
    slh_lamp_obs u_slh_lamp_obs (.pclk(pclk), .presetn(presetn),
        .clr(obs_clr), .lamp_run(lamp_run), .lamp_err(lamp_err),
        .changes(changes));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [11:0] node_a(input int i);
        return `SLH_A_NODE_BASE + 12'(4 * i);
    endfunction : node_a
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input string n);
        apb(1'b0, a, 32'h0);
        chk(n, q, e);
    endtask : rdchk
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic test_regs();
        int i;
        rdchk(`SLH_A_CTRL, 32'h08, "ctrl reset");
        for (i = 0; i < `SLH_NODES; i++) begin
            rdchk(node_a(i), 32'(`SLH_HC_STARTUP), "node reset");
            apb(1'b1, node_a(i), 32'(i + 3));
        end
        for (i = 0; i < `SLH_NODES; i++) begin
            rdchk(node_a(i), 32'(i + 3), "node code");
        end
        apb(1'b1, node_a(0), 32'h20);
        rdchk(node_a(0), 32'(`SLH_HC_MAX), "code clamp");
        rdchk(12'h100, 32'h0, "unmapped read");
        chk("unmapped err", 32'(err), 32'h1);
        $display("test regs done");
    endtask : test_regs
    task automatic test_run();
        logic [2:0] st [5];
        logic       op;
        int         i;
        st = '{`SLH_FSM_INIT, `SLH_FSM_PREOP, `SLH_FSM_BOOT,
               `SLH_FSM_SAFEOP, `SLH_FSM_OP};
        for (i = 0; i < 5; i++) begin
            op = st[i] == `SLH_FSM_OP;
            apb(1'b1, `SLH_A_CTRL, {25'h0, st[i], 4'h8});
            settle(2);
            chk("safe flag", 32'(outputs_safe), 32'(!op));
            if (st[i] != `SLH_FSM_PREOP && st[i] != `SLH_FSM_SAFEOP) begin
                chk("run lamp", 32'(lamp_run), 32'(op));
            end
        end
        $display("test run done");
    endtask : test_run
    task automatic test_err();
        apb(1'b1, `SLH_A_NODE_CFG, 32'h1);
        apb(1'b1, node_a(0), 32'h0);
        apb(1'b1, `SLH_A_IRQ_MASK, 32'h0);
        apb(1'b1, `SLH_A_IRQ_STAT, 32'h7);
        settle(2);
        chk("err lamp dark", 32'(lamp_err), 32'h0);
        chk("irq idle", 32'(irq), 32'h0);
        apb(1'b1, node_a(0), 32'(`SLH_HC_ABSENT));
        settle(4);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, `SLH_A_IRQ_MASK, 32'h7);
        settle(1);
        chk("irq fault", 32'(irq), 32'h1);
        apb(1'b1, `SLH_A_IRQ_STAT, 32'h2);
        settle(2);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("test err done");
    endtask : test_err
    task automatic test_busoff();
        obs_clr     <= 1'b1;
        can_bus_off <= 1'b1;
        @(posedge pclk);
        obs_clr <= 1'b0;
        settle(5);
        chk("busoff lamp", 32'(lamp_err), 32'h1);
        rdchk(node_a(3), 32'(`SLH_HC_BUSOFF), "busoff code");
        apb(1'b1, node_a(3), 32'h1);
        rdchk(node_a(3), 32'(`SLH_HC_BUSOFF), "code refused");
        // upload on top of bus-off; the steady lamp must win
        apb(1'b1, `SLH_A_CTRL, 32'h49);
        can_bus_off <= 1'b0;
        settle(20);
        chk("busoff held", 32'(lamp_err), 32'h1);
        chk("lamp changes", 32'(changes), 32'h1);
        apb(1'b0, `SLH_A_IRQ_STAT, 32'h0);
        chk("busoff irq", 32'(q[`SLH_E_BUSOFF]), 32'h1);
        apb(1'b1, `SLH_A_CTRL, 32'hc8);
        apb(1'b1, `SLH_A_CTRL, 32'h48);
        apb(1'b1, node_a(3), 32'h0);
        rdchk(node_a(3), 32'h0, "after restart");
        $display("test busoff done");
    endtask : test_busoff
    task automatic test_cpu();
        cpu_starting <= 1'b1;
        cpu_error    <= 1'b1;
        settle(6);
        chk("cpu pin", 32'(lamp_cpu), 32'h1);
        apb(1'b1, `SLH_A_CTRL, 32'h4c);
        cpu_error <= 1'b0;
        settle(6);
        chk("cpu ctrl", 32'(lamp_cpu), 32'h1);
        $display("test cpu done");
    endtask : test_cpu
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        presetn = 1'b0;
        ce      = 1'b1;
        {psel, penable, pwrite, can_bus_off, cpu_starting, cpu_error,
         obs_clr} = '0;
        paddr   = '0;
        pwdata  = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_run();
        test_err();
        test_busoff();
        test_cpu();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
